/* rtl/ttb_defines.vh */
// register offsets, field positions and reset values of the time-base unit
`ifndef TTB_DEFINES_VH
`define TTB_DEFINES_VH

`define TTB_ADDR_W        4
`define TTB_OFS_CTRL      4'h0
`define TTB_OFS_EVGEN     4'h1
`define TTB_OFS_FLAG      4'h2
`define TTB_OFS_COUNT     4'h3
`define TTB_OFS_PRESCALE  4'h4
`define TTB_OFS_RELOAD    4'h5
`define TTB_OFS_CHMODE    4'h6
`define TTB_OFS_CHEN      4'h7
`define TTB_OFS_OPTION    4'h8
`define TTB_OFS_STATUS    4'h9

`define TTB_CTRL_CEN      0
`define TTB_CTRL_UDIS     1
`define TTB_CTRL_URS      2
`define TTB_CTRL_DIR      4
`define TTB_CTRL_ARBE     7
`define TTB_CTRL_ECM0     8
`define TTB_CTRL_ECM1     9
`define TTB_EVGEN_UG      0
`define TTB_FLAG_UIF      0
`define TTB_PSC_W         4

`define TTB_CTRL_RST      16'h0000
`define TTB_RELOAD_RST    16'hFFFF
`define TTB_COUNT_RST     16'h0000
`define TTB_PSC_RST       4'h0

`endif

/* rtl/ttb_time_base.v */
// time-base unit: 16-bit up/down counter, power-of-two prescaler, buffered reload
// Operation
// - 16-bit counter with reload register; counts up or down.
// - prescaler divides by 2^exponent (4-bit field) using a 16-bit counter.
// - prescaler writes buffered, take effect at next update event.
// - count, prescale and reload readable and writable any time.
// - reload buffer passes through unless buffering enabled, then at update.
// - update on overflow/underflow when update-disable clear, or by software.
// - counter advances on prescaler tick only while run gate set, which follows the enable bit one clock late.
// - run gate goes active one clock after enable bit set.
// - counter keeps running while the core is halted for debug.
// - up mode: 0 to reload, then wrap to 0 with overflow.
// - down mode: reload down to 0, then reload with underflow.
// - update-disable set blocks overflow/underflow updates and their shadow loads; forced and slave updates still occur.
// - up mode forced update restarts counter and prescaler at 0.
// - down mode forced update restarts counter at reload, prescaler at 0.
// - request-source set: force update still updates but sets no flag.
// - update sets flag unless forced with request-source set, loads active prescale ratio.
// - active reload loaded before counter reload at update.
// - slave controller may also raise an update event.
// - timer output owns pin only while channel output-configured and enabled.
// - second timer has four remap bits: 0 port A, 1 port B.
// - ext clock and mask pins act only in external clock modes.
// - each timer instance is independent with no shared resources.
`timescale 1ns/10ps
`include "ttb_defines.vh"

module ttb_time_base #(
  parameter CNT_W       = 16,
  parameter IS_SECOND   = 0
) (
  // clock and reset
  input  wire                   clk,
  input  wire                   nrst,
  // register port
  input  wire [`TTB_ADDR_W-1:0] regAddr,
  input  wire [15:0]            regWdata,
  input  wire                   regWrite,
  input  wire                   regRead,
  output reg  [15:0]            regRdata,
  // slave controller update request
  input  wire                   slaveUpdate,
  // external clock and mask pins
  input  wire                   extClockPin,
  input  wire                   clockMaskPin,
  // pin routing
  output reg  [3:0]             channelOwnsPin,
  output reg  [3:0]             channelRemapSelect,
  // event outputs
  output reg                    updateEvent,
  output reg                    updateFlag
);

  ////////////////////////////////////////////////////////////////////////////
  reg [15:0]          controlOne_reg;
  reg [15:0]          reloadBuf_reg;
  reg [15:0]          reloadAct_reg;
  reg [`TTB_PSC_W-1:0] pscBuf_reg;
  reg [`TTB_PSC_W-1:0] pscAct_reg;
  reg [15:0]          pscCnt_reg;
  reg [CNT_W-1:0]     count_reg;
  reg                 runGate_reg;
  reg                 forceUpdate_reg;
  reg [15:0]          chMode_reg;
  reg [3:0]           chEnable_reg;
  reg [3:0]           remap_reg;
  reg                 extLast_reg;

  wire counterEnableBit = controlOne_reg[`TTB_CTRL_CEN];
  wire updateDisable    = controlOne_reg[`TTB_CTRL_UDIS];
  wire updateReqSource  = controlOne_reg[`TTB_CTRL_URS];
  wire countDown        = controlOne_reg[`TTB_CTRL_DIR];
  wire reloadBufEnable  = controlOne_reg[`TTB_CTRL_ARBE];
  wire extClockMode     = controlOne_reg[`TTB_CTRL_ECM0] | controlOne_reg[`TTB_CTRL_ECM1];

  wire wrCtrl  = regWrite && (regAddr == `TTB_OFS_CTRL);
  wire wrEvgen = regWrite && (regAddr == `TTB_OFS_EVGEN);
  wire wrFlag  = regWrite && (regAddr == `TTB_OFS_FLAG);
  wire wrCount = regWrite && (regAddr == `TTB_OFS_COUNT);
  wire wrPsc   = regWrite && (regAddr == `TTB_OFS_PRESCALE);
  wire wrRel   = regWrite && (regAddr == `TTB_OFS_RELOAD);

  ////////////////////////////////////////////////////////////////////////////
  // gated external clock edge; pins ignored outside external clock modes
  wire extLevel  = extClockPin & (controlOne_reg[`TTB_CTRL_ECM1] ? clockMaskPin : 1'b1);
  wire extEdge   = extClockMode & extLevel & ~extLast_reg;
  wire clockIn   = extClockMode ? extEdge : 1'b1;

  // prescaler: ratio minus one built from exponent
  wire [15:0] pscLimit = (16'h0001 << pscAct_reg) - 16'h0001;
  wire        pscTick  = runGate_reg && clockIn && (pscCnt_reg == pscLimit);
  wire        counterClockTick = pscTick;

  wire [CNT_W-1:0] relNow = reloadAct_reg[CNT_W-1:0];
  wire overflow  = counterClockTick && !countDown && (count_reg == relNow);
  wire underflow = counterClockTick && countDown && (count_reg == {CNT_W{1'b0}});
  wire swUpdate  = forceUpdate_reg | slaveUpdate;
  wire updateNow = swUpdate | ((overflow | underflow) & ~updateDisable);
  wire setFlag   = slaveUpdate | (forceUpdate_reg & ~updateReqSource)
                 | ((overflow | underflow) & ~updateDisable);

  // count widened for the 16-bit read path without a zero-width replication
  wire [31:0] countPad = {{(32-CNT_W){1'b0}}, count_reg};

  // reload seen by counter this cycle: new value first at update
  wire [15:0] reloadNext = (!reloadBufEnable || updateNow) ? reloadBuf_reg : reloadAct_reg;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      controlOne_reg  <= `TTB_CTRL_RST;
      reloadBuf_reg   <= `TTB_RELOAD_RST;
      reloadAct_reg   <= `TTB_RELOAD_RST;
      pscBuf_reg      <= `TTB_PSC_RST;
      pscAct_reg      <= `TTB_PSC_RST;
      pscCnt_reg      <= 16'h0000;
      count_reg       <= {CNT_W{1'b0}};
      runGate_reg     <= 1'b0;
      forceUpdate_reg <= 1'b0;
      chMode_reg      <= 16'h0000;
      chEnable_reg    <= 4'h0;
      remap_reg       <= 4'h0;
      extLast_reg     <= 1'b0;
      updateEvent     <= 1'b0;
      updateFlag      <= 1'b0;
    end else begin
      if (wrCtrl) begin
        controlOne_reg <= regWdata;
      end
      runGate_reg     <= counterEnableBit;
      forceUpdate_reg <= wrEvgen & regWdata[`TTB_EVGEN_UG];
      extLast_reg     <= extLevel;
      if (wrPsc) begin
        pscBuf_reg <= regWdata[`TTB_PSC_W-1:0];
      end
      if (wrRel) begin
        reloadBuf_reg <= regWdata;
      end
      if (!reloadBufEnable || updateNow) begin
        reloadAct_reg <= reloadBuf_reg;
      end
      if (updateNow) begin
        pscAct_reg <= pscBuf_reg;
      end
      // prescaler counter
      if (swUpdate) begin
        pscCnt_reg <= 16'h0000;
      end else if (runGate_reg && clockIn) begin
        pscCnt_reg <= pscTick ? 16'h0000 : pscCnt_reg + 16'h0001;
      end
      // main counter
      if (swUpdate) begin
        count_reg <= countDown ? reloadNext[CNT_W-1:0] : {CNT_W{1'b0}};
      end else if (wrCount) begin
        count_reg <= regWdata[CNT_W-1:0];
      end else if (counterClockTick) begin
        if (countDown) begin
          count_reg <= underflow ? reloadNext[CNT_W-1:0] : count_reg - 1'b1;
        end else begin
          count_reg <= overflow ? {CNT_W{1'b0}} : count_reg + 1'b1;
        end
      end
      updateEvent <= updateNow;
      // set wins over a software clear
      if (setFlag) begin
        updateFlag <= 1'b1;
      end else if (wrFlag && regWdata[`TTB_FLAG_UIF]) begin
        updateFlag <= 1'b0;
      end
      if (regWrite && regAddr == `TTB_OFS_CHMODE) begin
        chMode_reg <= regWdata;
      end
      if (regWrite && regAddr == `TTB_OFS_CHEN) begin
        chEnable_reg <= regWdata[3:0];
      end
      if (regWrite && regAddr == `TTB_OFS_OPTION && IS_SECOND != 0) begin
        remap_reg <= regWdata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin ownership per channel: output mode (select field 00) and enabled
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : gOwn
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          channelOwnsPin[ch]     <= 1'b0;
          channelRemapSelect[ch] <= 1'b0;
        end else begin
          channelOwnsPin[ch]     <= (chMode_reg[4*ch+1 -: 2] == 2'b00) & chEnable_reg[ch];
          channelRemapSelect[ch] <= remap_reg[ch];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read data one cycle after the strobe; unmapped reads zero
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 16'h0000;
    end else if (regRead) begin
      case (regAddr)
        `TTB_OFS_CTRL:     regRdata <= controlOne_reg;
        `TTB_OFS_FLAG:     regRdata <= {15'h0000, updateFlag};
        `TTB_OFS_COUNT:    regRdata <= countPad[15:0];
        `TTB_OFS_PRESCALE: regRdata <= {12'h000, pscBuf_reg};
        `TTB_OFS_RELOAD:   regRdata <= reloadBuf_reg;
        `TTB_OFS_CHMODE:   regRdata <= chMode_reg;
        `TTB_OFS_CHEN:     regRdata <= {12'h000, chEnable_reg};
        `TTB_OFS_OPTION:   regRdata <= {12'h000, remap_reg};
        `TTB_OFS_STATUS:   regRdata <= {12'h000, pscAct_reg};
        default:           regRdata <= 16'h0000;
      endcase
    end else begin
      regRdata <= 16'h0000;
    end
  end

endmodule

/* test/ttb_time_base_sva.sv */
// assertion checker on the time-base unit ports
`timescale 1ns/10ps
`include "ttb_defines.vh"
module ttb_time_base_sva #(parameter IS_SECOND = 0) (
  // clock, reset and register port
  input logic        clk,
  input logic        nrst,
  input logic [3:0]  regAddr,
  input logic [15:0] regWdata,
  input logic        regWrite,
  input logic        regRead,
  input logic [15:0] regRdata,
  // events and pins
  input logic        slaveUpdate,
  input logic        extClockPin,
  input logic        clockMaskPin,
  input logic [3:0]  channelOwnsPin,
  input logic [3:0]  channelRemapSelect,
  input logic        updateEvent,
  input logic        updateFlag
);
  logic [15:0] ctl;
  logic [15:0] cmode;
  logic [3:0]  cen;
  logic [3:0]  opt;
  wire fw = regWrite && regAddr == `TTB_OFS_EVGEN && regWdata[0];
  wire fc = regWrite && regAddr == `TTB_OFS_FLAG && regWdata[0];
  wire [3:0] own = cen & {cmode[13:12] == 2'h0, cmode[9:8] == 2'h0, cmode[5:4] == 2'h0,
                          cmode[1:0] == 2'h0};
  wire [3:0] rmp = (IS_SECOND != 0) ? opt : 4'h0;
  // shadow copies of software-written fields
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl <= 16'h0000;
      cmode <= 16'h0000;
      cen <= 4'h0;
      opt <= 4'h0;
    end else if (regWrite) begin
      if (regAddr == `TTB_OFS_CTRL) ctl <= regWdata;
      if (regAddr == `TTB_OFS_CHMODE) cmode <= regWdata;
      if (regAddr == `TTB_OFS_CHEN) cen <= regWdata[3:0];
      if (regAddr == `TTB_OFS_OPTION) opt <= regWdata[3:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_rdata_idle: assert property (!regRead |=> regRdata == 16'h0000)
    else $error("read data not zero when idle");
  chk_force_event: assert property (fw |-> ##2 updateEvent)
    else $error("forced update gave no event");
  chk_slave_event: assert property (slaveUpdate |-> ##[1:2] updateEvent)
    else $error("slave update gave no event");
  chk_flag_cause: assert property ($rose(updateFlag) |-> updateEvent)
    else $error("flag set without update event");
  chk_flag_sticky: assert property (updateFlag && !fc |=> updateFlag)
    else $error("flag dropped without clear");
  chk_urs_quiet: assert property (fw && ctl[2] && !ctl[0] && !updateFlag && !slaveUpdate
    && !$past(slaveUpdate) |=> !updateFlag [*3])
    else $error("flag set by forced update with request source");
  chk_flag_clear: assert property (fc && !ctl[0] && !slaveUpdate && !$past(slaveUpdate)
    && !$past(fw) |=> !updateFlag)
    else $error("flag not cleared");
  chk_pin_owner: assert property (!regWrite && !$past(regWrite) |-> channelOwnsPin == own)
    else $error("pin ownership wrong");
  chk_remap_sel: assert property (!regWrite && !$past(regWrite) |-> channelRemapSelect == rmp)
    else $error("remap select wrong");
  cover property (fw ##2 updateEvent);
  cover property ($rose(updateFlag));
  cover property (slaveUpdate);
endmodule

/* test/tb_top.sv */
// self-checking testbench of the time-base unit
`timescale 1ns/10ps
`include "ttb_defines.vh"
module tb_top;
  logic clk = 0, nrst = 0, regWrite = 0, regRead = 0, slaveUpdate = 0;
  logic extPin = 0, maskPin = 0;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  wire  [15:0] regRdata;
  wire  [3:0]  owns, remap;
  wire         ev, flag;
  int          errors = 0, n_checks = 0, cyc = 0;
  always #25 clk = ~clk;
  ttb_time_base #(.IS_SECOND(1)) uut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .slaveUpdate(slaveUpdate), .extClockPin(extPin), .clockMaskPin(maskPin),
    .channelOwnsPin(owns), .channelRemapSelect(remap), .updateEvent(ev), .updateFlag(flag));
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 20000) begin errors++; complete_run; end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin errors++; $display("MISMATCH %0t %h %h", $time, got, exp); end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) begin regAddr <= a; regWdata <= d; regWrite <= 1'b1; end
    @(posedge clk) regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk) begin regAddr <= a; regRead <= 1'b1; end
    @(posedge clk) regRead <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  task automatic wait_ev(output int n);
    n = 0;
    while (ev !== 1'b1 && n < 3000) begin @(posedge clk); #1 n++; end
  endtask
  task automatic period(input int exp);
    int n;
    #1 wait_ev(n);
    @(posedge clk); #1 wait_ev(n);
    @(posedge clk); #1 wait_ev(n);
    chk(16'(n + 1), 16'(exp));
  endtask
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge clk) extPin <= 1'b1;
      @(posedge clk) extPin <= 1'b0;
      @(posedge clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(`TTB_OFS_RELOAD, 16'hFFFF);
    rd(4'hF, 16'h0000);
    wr(`TTB_OFS_COUNT, 16'h1234);
    rd(`TTB_OFS_COUNT, 16'h1234);
    wr(`TTB_OFS_PRESCALE, 16'h0005);
    rd(`TTB_OFS_STATUS, 16'h0000);
    wr(`TTB_OFS_EVGEN, 16'h0001);
    rd(`TTB_OFS_STATUS, 16'h0005);
    rd(`TTB_OFS_COUNT, 16'h0000);
    rd(`TTB_OFS_FLAG, 16'h0001);
    wr(`TTB_OFS_PRESCALE, 16'h0000);
    wr(`TTB_OFS_EVGEN, 16'h0001);
    wr(`TTB_OFS_FLAG, 16'h0001);
    rd(`TTB_OFS_FLAG, 16'h0000);
    $display("t_regs done");
  endtask
  task automatic t_down;
    wr(`TTB_OFS_RELOAD, 16'h0005);
    wr(`TTB_OFS_CTRL, 16'h0014);
    wr(`TTB_OFS_EVGEN, 16'h0001);
    rd(`TTB_OFS_COUNT, 16'h0005);
    rd(`TTB_OFS_FLAG, 16'h0000);
    @(posedge clk) slaveUpdate <= 1'b1;
    @(posedge clk) slaveUpdate <= 1'b0;
    repeat (3) @(posedge clk);
    rd(`TTB_OFS_FLAG, 16'h0001);
    wr(`TTB_OFS_FLAG, 16'h0001);
    $display("t_down done");
  endtask
  task automatic t_count;
    int seen = 0;
    wr(`TTB_OFS_RELOAD, 16'h0003);
    wr(`TTB_OFS_COUNT, 16'h0000);
    wr(`TTB_OFS_CTRL, 16'h0001);
    period(4);
    wr(`TTB_OFS_CTRL, 16'h0011);
    period(4);
    wr(`TTB_OFS_PRESCALE, 16'h0001);
    period(8);
    wr(`TTB_OFS_CTRL, 16'h0091);
    wr(`TTB_OFS_RELOAD, 16'h0001);
    period(4);
    wr(`TTB_OFS_CTRL, 16'h0093);
    repeat (2) @(posedge clk);
    repeat (40) @(posedge clk) if (ev !== 1'b0) seen++;
    chk(16'(seen), 16'h0000);
    wr(`TTB_OFS_CTRL, 16'h0000);
    $display("t_count done");
  endtask
  task automatic t_ext;
    wr(`TTB_OFS_RELOAD, 16'h00FF);
    wr(`TTB_OFS_PRESCALE, 16'h0000);
    wr(`TTB_OFS_EVGEN, 16'h0001);
    wr(`TTB_OFS_CTRL, 16'h0100);
    pulse(2);
    rd(`TTB_OFS_COUNT, 16'h0000);
    wr(`TTB_OFS_CTRL, 16'h0101);
    pulse(3);
    rd(`TTB_OFS_COUNT, 16'h0003);
    wr(`TTB_OFS_CTRL, 16'h0301);
    pulse(2);
    rd(`TTB_OFS_COUNT, 16'h0003);
    wr(`TTB_OFS_CTRL, 16'h0000);
    $display("t_ext done");
  endtask
  task automatic t_pins;
    wr(`TTB_OFS_CHEN, 16'h000F);
    wr(`TTB_OFS_CHMODE, 16'h0010);
    repeat (2) @(posedge clk);
    #1 chk({12'h000, owns}, 16'h000D);
    wr(`TTB_OFS_OPTION, 16'h0005);
    repeat (2) @(posedge clk);
    #1 chk({12'h000, remap}, 16'h0005);
    $display("t_pins done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_down;
    t_count;
    t_ext;
    t_pins;
    complete_run;
  end
endmodule
bind ttb_time_base ttb_time_base_sva #(.IS_SECOND(IS_SECOND)) chk_i (.clk(clk), .nrst(nrst),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .slaveUpdate(slaveUpdate), .extClockPin(extClockPin),
  .clockMaskPin(clockMaskPin), .channelOwnsPin(channelOwnsPin),
  .channelRemapSelect(channelRemapSelect), .updateEvent(updateEvent), .updateFlag(updateFlag));
